// >>> core/cbwd_pkg.sv
// constants, field layouts and carrier types for the per-socket
// configuration and window decode block of a card-bus bridge
// assumes one socket function per instance and a byte-offset config port
// How it works
// RULE_01 - own 8-bit secondary bus number, reset zero
// RULE_02 - forward decision uses primary, secondary, subordinate
// RULE_03 - 8-bit subordinate bus number, reset zero
// RULE_04 - tenure timer counts card clocks from frame
// RULE_05 - on expiry end after next data phase
// RULE_06 - software should program timer at least 20h
// RULE_07 - memory bases writable in bits 31-12
// RULE_08 - memory low twelve bits read zero
// RULE_09 - memory limits writable bits 31-12, reset zero
// RULE_10 - memory windows steer traffic both directions
// RULE_11 - memory window live only if nonzero
// RULE_12 - bridge control bits 8, 9 select prefetch
// RULE_13 - io base upper half reads zero
// RULE_14 - io base bits 1-0 zero, 15-2 writable
// RULE_15 - io window live only if nonzero
// RULE_16 - io windows steer traffic both directions
// RULE_17 - io limit low two bits taken as ones
// RULE_18 - window 1 prefetch select resets prefetchable
// RULE_19 - memory hit: base <= addr <= limit|FFFh
// RULE_20 - bus above secondary up to subordinate: type 1
package cbwd_pkg;
  // byte offsets of the documented registers
  localparam logic [7:0] OFS_PRI_BUS = 8'h18;
  localparam logic [7:0] OFS_SEC_BUS = 8'h19;
  localparam logic [7:0] OFS_SUB_BUS = 8'h1A;
  localparam logic [7:0] OFS_TENURE = 8'h1B;
  localparam logic [7:0] OFS_MEM0_BASE = 8'h1C;
  localparam logic [7:0] OFS_MEM0_LIMIT = 8'h20;
  localparam logic [7:0] OFS_MEM1_BASE = 8'h24;
  localparam logic [7:0] OFS_MEM1_LIMIT = 8'h28;
  localparam logic [7:0] OFS_IO0_BASE = 8'h2C;
  localparam logic [7:0] OFS_IO0_LIMIT = 8'h30;
  localparam logic [7:0] OFS_IO1_BASE = 8'h34;
  localparam logic [7:0] OFS_IO1_LIMIT = 8'h38;
  localparam logic [7:0] OFS_BRIDGE_CTL = 8'h3E;
  // writable masks and implied low bits
  localparam logic [31:0] MEM_WR_MASK = 32'hFFFFF000;
  localparam logic [31:0] MEM_LIMIT_ONES = 32'h00000FFF;
  localparam logic [31:0] IO_WR_MASK = 32'h0000FFFC;
  localparam logic [31:0] IO_LIMIT_ONES = 32'h00000003;
  // bridge control prefetch field
  localparam int PREF_LSB = 8;
  // reset values and advised tenure minimum
  localparam logic [7:0] BUS_NUM_RST = 8'h00;
  localparam logic [7:0] TENURE_RST = 8'h00;
  localparam logic [31:0] WINDOW_RST = 32'h00000000;
  localparam logic [1:0] PREF_RST = 2'h3;
  localparam logic [7:0] TENURE_ADVISED_MIN = 8'h20;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } cbwd_cfg_req_s;

  typedef struct packed {
    logic valid;
    logic is_io;
    logic [31:0] addr;
  } cbwd_xact_s;

  typedef enum logic [2:0] {
    TEN_IDLE = 3'b001,
    TEN_COUNT = 3'b010,
    TEN_EXPIRED = 3'b100
  } cbwd_tenure_e;
endpackage

// >>> core/cbwd_window_decode.sv
// configuration registers, window decode and initiator tenure timer
// of one card-bus socket function
// assumes all inputs synchronous to core_clk; cclk_tick marks card clocks
`timescale 1ns/1ns
`default_nettype none
module cbwd_window_decode
  import cbwd_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire cbwd_cfg_req_s cfg_req,
  output logic [31:0] cfg_rdata,
  output logic cfg_rvalid,
  input wire cbwd_xact_s host_xact,
  output logic to_card,
  output logic to_card_pref,
  input wire cbwd_xact_s card_xact,
  output logic to_host,
  input wire logic cfg_cyc_valid,
  input wire logic [7:0] cfg_cyc_bus,
  output logic cfg_local,
  output logic cfg_type0,
  output logic cfg_type1,
  input wire logic cclk_tick,
  input wire logic frame_start,
  input wire logic init_active,
  input wire logic data_phase_done,
  output logic tenure_expired,
  output logic end_xact
);

  // merge written byte lanes into the old word, then keep writable bits
  function automatic logic [31:0] merge_be(input logic [31:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0] be,
                                           input logic [31:0] mask);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        m[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return m & mask;
  endfunction

  // window hit, limit widened by its implied low ones
  function automatic logic in_window(input logic [31:0] a,
                                     input logic [31:0] base,
                                     input logic [31:0] limit,
                                     input logic [31:0] ones);
    return ((base != 32'h00000000) || (limit != 32'h00000000)) &&
           (a >= base) && (a <= (limit | ones));
  endfunction

  logic [7:0] pri_bus_r, pri_bus_nxt;
  logic [7:0] sec_bus_r, sec_bus_nxt;
  logic [7:0] sub_bus_r, sub_bus_nxt;
  logic [7:0] tenure_r, tenure_nxt;
  logic [31:0] mbase_r [2];
  logic [31:0] mbase_nxt [2];
  logic [31:0] mlim_r [2];
  logic [31:0] mlim_nxt [2];
  logic [31:0] iobase_r [2];
  logic [31:0] iobase_nxt [2];
  logic [31:0] iolim_r [2];
  logic [31:0] iolim_nxt [2];
  logic [1:0] pref_r, pref_nxt;
  logic [31:0] rdata_nxt;
  logic [5:0] dw;
  logic [31:0] word18;

  assign dw = cfg_req.addr[7:2];
  assign word18 = {tenure_r, sub_bus_r, sec_bus_r, pri_bus_r};

  // register writes; only whole dword decode, bytes picked by be
  always_comb begin
    logic [31:0] w;
    w = 32'h00000000;
    pri_bus_nxt = pri_bus_r;
    sec_bus_nxt = sec_bus_r;
    sub_bus_nxt = sub_bus_r;
    tenure_nxt = tenure_r;
    pref_nxt = pref_r;
    for (int k = 0; k < 2; k++) begin
      mbase_nxt[k] = mbase_r[k];
      mlim_nxt[k] = mlim_r[k];
      iobase_nxt[k] = iobase_r[k];
      iolim_nxt[k] = iolim_r[k];
    end
    if (cfg_req.wr) begin
      if (dw == OFS_PRI_BUS[7:2]) begin
        w = merge_be(word18, cfg_req.wdata, cfg_req.be, 32'hFFFFFFFF);
        pri_bus_nxt = w[7:0];
        sec_bus_nxt = w[15:8]; // RULE_01
        sub_bus_nxt = w[23:16]; // RULE_03
        tenure_nxt = w[31:24];
      end else if (dw == OFS_MEM0_BASE[7:2]) begin
        mbase_nxt[0] = merge_be(mbase_r[0], cfg_req.wdata, cfg_req.be,
                                MEM_WR_MASK); // RULE_07 RULE_08
      end else if (dw == OFS_MEM0_LIMIT[7:2]) begin
        mlim_nxt[0] = merge_be(mlim_r[0], cfg_req.wdata, cfg_req.be,
                               MEM_WR_MASK); // RULE_09 RULE_08
      end else if (dw == OFS_MEM1_BASE[7:2]) begin
        mbase_nxt[1] = merge_be(mbase_r[1], cfg_req.wdata, cfg_req.be,
                                MEM_WR_MASK); // RULE_07
      end else if (dw == OFS_MEM1_LIMIT[7:2]) begin
        mlim_nxt[1] = merge_be(mlim_r[1], cfg_req.wdata, cfg_req.be,
                               MEM_WR_MASK); // RULE_09
      end else if (dw == OFS_IO0_BASE[7:2]) begin
        iobase_nxt[0] = merge_be(iobase_r[0], cfg_req.wdata, cfg_req.be,
                                 IO_WR_MASK); // RULE_13 RULE_14
      end else if (dw == OFS_IO0_LIMIT[7:2]) begin
        iolim_nxt[0] = merge_be(iolim_r[0], cfg_req.wdata, cfg_req.be,
                                IO_WR_MASK);
      end else if (dw == OFS_IO1_BASE[7:2]) begin
        iobase_nxt[1] = merge_be(iobase_r[1], cfg_req.wdata, cfg_req.be,
                                 IO_WR_MASK); // RULE_14
      end else if (dw == OFS_IO1_LIMIT[7:2]) begin
        iolim_nxt[1] = merge_be(iolim_r[1], cfg_req.wdata, cfg_req.be,
                                IO_WR_MASK);
      end else if (dw == OFS_BRIDGE_CTL[7:2]) begin
        // only the prefetch pair lives here; other control bits elsewhere
        if (cfg_req.be[3]) begin
          pref_nxt = cfg_req.wdata[16+PREF_LSB +: 2]; // RULE_12
        end
      end
    end
  end

  // read mux; unmapped offsets return zero
  always_comb begin
    rdata_nxt = 32'h00000000;
    if (dw == OFS_PRI_BUS[7:2]) begin
      rdata_nxt = word18;
    end else if (dw == OFS_MEM0_BASE[7:2]) begin
      rdata_nxt = mbase_r[0];
    end else if (dw == OFS_MEM0_LIMIT[7:2]) begin
      rdata_nxt = mlim_r[0];
    end else if (dw == OFS_MEM1_BASE[7:2]) begin
      rdata_nxt = mbase_r[1];
    end else if (dw == OFS_MEM1_LIMIT[7:2]) begin
      rdata_nxt = mlim_r[1];
    end else if (dw == OFS_IO0_BASE[7:2]) begin
      rdata_nxt = iobase_r[0];
    end else if (dw == OFS_IO0_LIMIT[7:2]) begin
      rdata_nxt = iolim_r[0];
    end else if (dw == OFS_IO1_BASE[7:2]) begin
      rdata_nxt = iobase_r[1];
    end else if (dw == OFS_IO1_LIMIT[7:2]) begin
      rdata_nxt = iolim_r[1];
    end else if (dw == OFS_BRIDGE_CTL[7:2]) begin
      rdata_nxt = {6'h00, pref_r, 24'h000000}; // bridge control bits 9:8
    end
  end

  // register file state
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pri_bus_r <= BUS_NUM_RST;
      sec_bus_r <= BUS_NUM_RST;
      sub_bus_r <= BUS_NUM_RST;
      tenure_r <= TENURE_RST;
      pref_r <= PREF_RST; // RULE_18
      for (int k = 0; k < 2; k++) begin
        mbase_r[k] <= WINDOW_RST;
        mlim_r[k] <= WINDOW_RST;
        iobase_r[k] <= WINDOW_RST;
        iolim_r[k] <= WINDOW_RST;
      end
      cfg_rdata <= 32'h00000000;
      cfg_rvalid <= 1'b0;
    end else if (clk_en) begin
      pri_bus_r <= pri_bus_nxt;
      sec_bus_r <= sec_bus_nxt;
      sub_bus_r <= sub_bus_nxt;
      tenure_r <= tenure_nxt;
      pref_r <= pref_nxt;
      for (int k = 0; k < 2; k++) begin
        mbase_r[k] <= mbase_nxt[k];
        mlim_r[k] <= mlim_nxt[k];
        iobase_r[k] <= iobase_nxt[k];
        iolim_r[k] <= iolim_nxt[k];
      end
      cfg_rdata <= cfg_req.rd ? rdata_nxt : 32'h00000000;
      cfg_rvalid <= cfg_req.rd;
    end
  end

  // window and bus-number decode, registered one cycle
  logic [1:0] mhit_h, iohit_h, mhit_c, iohit_c;
  logic to_card_nxt, pref_nxt_o, to_host_nxt;
  logic local_nxt, t0_nxt, t1_nxt;
  always_comb begin
    for (int k = 0; k < 2; k++) begin
      mhit_h[k] = in_window(host_xact.addr, mbase_r[k], mlim_r[k],
                            MEM_LIMIT_ONES); // RULE_19 RULE_11
      iohit_h[k] = in_window(host_xact.addr, iobase_r[k], iolim_r[k],
                             IO_LIMIT_ONES); // RULE_17 RULE_15
      mhit_c[k] = in_window(card_xact.addr, mbase_r[k], mlim_r[k],
                            MEM_LIMIT_ONES);
      iohit_c[k] = in_window(card_xact.addr, iobase_r[k], iolim_r[k],
                             IO_LIMIT_ONES);
    end
    // host side claims inside a window, card side goes up outside all
    to_card_nxt = host_xact.valid &&
                  (host_xact.is_io ? |iohit_h : |mhit_h); // RULE_10 RULE_16
    pref_nxt_o = host_xact.valid && !host_xact.is_io &&
                 ((mhit_h[0] && pref_r[0]) ||
                  (!mhit_h[0] && mhit_h[1] && pref_r[1])); // RULE_12
    to_host_nxt = card_xact.valid &&
                  !(card_xact.is_io ? |iohit_c : |mhit_c); // RULE_10 RULE_16
    // bus matching: own bus is local, secondary type 0, above it up to subordinate type 1
    local_nxt = cfg_cyc_valid && (cfg_cyc_bus == pri_bus_r); // RULE_02
    t0_nxt = cfg_cyc_valid && !local_nxt && (cfg_cyc_bus == sec_bus_r);
    t1_nxt = cfg_cyc_valid && !local_nxt && (cfg_cyc_bus > sec_bus_r) &&
             (cfg_cyc_bus <= sub_bus_r); // RULE_20
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      to_card <= 1'b0;
      to_card_pref <= 1'b0;
      to_host <= 1'b0;
      cfg_local <= 1'b0;
      cfg_type0 <= 1'b0;
      cfg_type1 <= 1'b0;
    end else if (clk_en) begin
      to_card <= to_card_nxt;
      to_card_pref <= pref_nxt_o;
      to_host <= to_host_nxt;
      cfg_local <= local_nxt;
      cfg_type0 <= t0_nxt;
      cfg_type1 <= t1_nxt;
    end
  end

  // initiator tenure timer; a value under 20h is legal but cuts bursts
  cbwd_tenure_e ten_r, ten_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic end_nxt;
  always_comb begin
    ten_nxt = ten_r;
    cnt_nxt = cnt_r;
    end_nxt = 1'b0;
    case (ten_r)
      TEN_IDLE: begin
        if (frame_start) begin
          cnt_nxt = tenure_r; // RULE_04
          ten_nxt = (tenure_r == 8'h00) ? TEN_EXPIRED : TEN_COUNT;
        end
      end
      TEN_COUNT: begin
        if (!init_active) begin
          ten_nxt = TEN_IDLE;
        end else if (cclk_tick) begin
          cnt_nxt = cnt_r - 8'h01; // RULE_04
          if (cnt_r == 8'h01) begin
            ten_nxt = TEN_EXPIRED;
          end
        end
      end
      TEN_EXPIRED: begin
        if (!init_active) begin
          ten_nxt = TEN_IDLE;
        end else if (data_phase_done) begin
          end_nxt = 1'b1; // RULE_05
          ten_nxt = TEN_IDLE;
        end
      end
      default: ten_nxt = TEN_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ten_r <= TEN_IDLE;
      cnt_r <= 8'h00;
      end_xact <= 1'b0;
    end else if (clk_en) begin
      ten_r <= ten_nxt;
      cnt_r <= cnt_nxt;
      end_xact <= end_nxt;
    end
  end
  assign tenure_expired = (ten_r == TEN_EXPIRED);

  a_sec_bus_write: assert property (@(posedge core_clk) disable iff (!resetn)
    clk_en && cfg_req.wr && dw == OFS_SEC_BUS[7:2] && cfg_req.be[1]
    |=> sec_bus_r == $past(cfg_req.wdata[15:8]))
    else $error("secondary bus number not stored"); // RULE_01
  a_sub_bus_write: assert property (@(posedge core_clk) disable iff (!resetn)
    clk_en && cfg_req.wr && dw == OFS_SUB_BUS[7:2] && cfg_req.be[2]
    |=> sub_bus_r == $past(cfg_req.wdata[23:16]))
    else $error("subordinate bus number not stored"); // RULE_03
  a_mem_low_zero: assert property (@(posedge core_clk) disable iff (!resetn)
    clk_en && cfg_req.rd && dw >= OFS_MEM0_BASE[7:2] &&
    dw <= OFS_MEM1_LIMIT[7:2] |=> cfg_rvalid && cfg_rdata[11:0] == 12'h000)
    else $error("memory window low bits not zero"); // RULE_08
  a_io_base_bits: assert property (@(posedge core_clk) disable iff (!resetn)
    clk_en && cfg_req.rd && (dw == OFS_IO0_BASE[7:2] ||
    dw == OFS_IO1_BASE[7:2]) |=> cfg_rdata[31:16] == 16'h0000 &&
    cfg_rdata[1:0] == 2'h0)
    else $error("io base read-only bits not zero"); // RULE_14
  a_mem_off_zero: assert property (@(posedge core_clk) disable iff (!resetn)
    clk_en && host_xact.valid && !host_xact.is_io &&
    mbase_r[0] == 32'h0 && mlim_r[0] == 32'h0 &&
    mbase_r[1] == 32'h0 && mlim_r[1] == 32'h0 |=> !to_card)
    else $error("disabled memory window claimed"); // RULE_11
  a_type1_fwd: assert property (@(posedge core_clk) disable iff (!resetn)
    clk_en && cfg_cyc_valid && cfg_cyc_bus != pri_bus_r &&
    cfg_cyc_bus > sec_bus_r && cfg_cyc_bus <= sub_bus_r
    |=> cfg_type1 && !cfg_type0)
    else $error("type 1 forward missed"); // RULE_20
  a_tenure_load: assert property (@(posedge core_clk) disable iff (!resetn)
    clk_en && ten_r == TEN_IDLE && frame_start
    |=> cnt_r == $past(tenure_r))
    else $error("tenure timer not loaded at frame"); // RULE_04
  a_tenure_end: assert property (@(posedge core_clk) disable iff (!resetn)
    clk_en && tenure_expired && init_active && data_phase_done
    |=> end_xact ##1 !end_xact || !clk_en)
    else $error("expired tenure did not end transaction"); // RULE_05
  a_pref_select: assert property (@(posedge core_clk) disable iff (!resetn)
    clk_en && host_xact.valid && !host_xact.is_io && mhit_h == 2'b10
    |=> to_card && to_card_pref == $past(pref_r[1]))
    else $error("window 1 prefetch select ignored"); // RULE_12
endmodule
`default_nettype wire

// >>> test/cbwd_card_model.sv
// card-side initiator model: free card clock ticks, frame, data phases
// assumes go is a one-cycle pulse driven at a falling edge
`timescale 1ns/1ns
`default_nettype none
module cbwd_card_model
  import cbwd_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic go,
  input wire logic [7:0] phases,
  input wire logic end_xact,
  output logic cclk_tick,
  output logic frame_start,
  output logic init_active,
  output logic data_phase_done
);
  logic [1:0] ph_r;
  logic odd_r;
  logic [7:0] left_r;
  // falling-edge drive so the bridge sees settled levels; card clock
  // runs free, one data phase every second card clock
  always @(negedge core_clk or negedge resetn) begin
    if (!resetn) begin
      {ph_r, odd_r, left_r} <= '0;
      {cclk_tick, frame_start, init_active, data_phase_done} <= '0;
    end else begin
      frame_start <= 1'b0;
      data_phase_done <= 1'b0;
      ph_r <= ph_r + 2'h1;
      cclk_tick <= ph_r == 2'h3;
      if (!init_active && go) begin
        frame_start <= 1'b1;
        init_active <= 1'b1;
        left_r <= phases;
        odd_r <= 1'b0;
      end else if (init_active) begin
        if (end_xact || left_r == 8'h00) begin
          init_active <= 1'b0;
        end else if (cclk_tick) begin
          odd_r <= ~odd_r;
          if (odd_r) begin
            data_phase_done <= 1'b1;
            left_r <= left_r - 8'h01;
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> test/cbwd_window_decode_tb.sv
// self-checking bench: posedge mirror model compared at every falling edge
// assumes the card model above drives the tenure timer inputs
`timescale 1ns/1ns
`default_nettype none
module cbwd_window_decode_tb
  import cbwd_pkg::*;
  ;
  logic core_clk, resetn, clk_en, go, chk_on, cfg_rvalid, cfg_cyc_valid;
  logic to_card, to_card_pref, to_host, cfg_local, cfg_type0, cfg_type1;
  logic cclk_tick, frame_start, init_active, data_phase_done;
  logic tenure_expired, end_xact;
  logic [7:0] phases, cfg_cyc_bus;
  logic [31:0] cfg_rdata, st, r, wm, m [10];
  cbwd_cfg_req_s cfg_req;
  cbwd_xact_s host_xact, card_xact;
  logic [31:0] x_rd;
  logic x_rv, x_tc, x_tp, x_th, x_lo, x_t0, x_t1, x_end;
  int errors, n_checks, cyc, ts, tc, wi;

  cbwd_window_decode DUT (.core_clk, .resetn, .clk_en, .cfg_req, .cfg_rdata,
    .cfg_rvalid, .host_xact, .to_card, .to_card_pref, .card_xact, .to_host,
    .cfg_cyc_valid, .cfg_cyc_bus, .cfg_local, .cfg_type0, .cfg_type1,
    .cclk_tick, .frame_start, .init_active, .data_phase_done,
    .tenure_expired, .end_xact);
  cbwd_card_model PARTNER (.core_clk, .resetn, .go, .phases, .end_xact,
    .cclk_tick, .frame_start, .init_active, .data_phase_done);

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  function logic [31:0] xs();
    st = st ^ (st << 13);
    st = st ^ (st >> 17);
    st = st ^ (st << 5);
    return st;
  endfunction
  function automatic int ix(logic [7:0] a);
    return (a >= 8'h18 && a <= 8'h3F) ? int'(a[7:2]) - 6 : 10;
  endfunction
  function automatic logic [31:0] mk(int i);
    return i == 0 ? 32'hFFFFFFFF : i < 5 ? 32'hFFFFF000 :
      i < 9 ? 32'h0000FFFC : 32'h03000000;
  endfunction
  function automatic logic mh(int w, logic [31:0] a);
    logic [31:0] b = m[1 + 2 * w];
    logic [31:0] l = m[2 + 2 * w];
    return (b | l) != 0 && a >= b && a <= (l | 32'h00000FFF);
  endfunction
  function automatic logic ih(int w, logic [31:0] a);
    logic [31:0] b = m[5 + 2 * w];
    logic [31:0] l = m[6 + 2 * w];
    return (b | l) != 0 && a >= b && a <= (l | 32'h00000003);
  endfunction
  function automatic logic hit(logic io, logic [31:0] a);
    return io ? ih(0, a) || ih(1, a) : mh(0, a) || mh(1, a);
  endfunction
  // addresses cluster around window edges so both sides get exercised
  function automatic logic [31:0] pick(logic [31:0] v);
    return m[1 + v[2:0]] + (v[3] ? 32'h00000FFC : 32'h0) + v[6:4] - 32'd3;
  endfunction

  // mirror of the block: decode sees register values before this write
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      m = '{default: '0};
      m[9] = 32'h03000000;
      {x_rd, x_rv, x_tc, x_tp, x_th, x_lo, x_t0, x_t1, x_end} = '0;
      ts = 0;
      tc = 0;
    end else if (clk_en) begin
      x_rv = cfg_req.rd;
      x_rd = (cfg_req.rd && ix(cfg_req.addr) < 10) ? m[ix(cfg_req.addr)] : '0;
      x_tc = host_xact.valid && hit(host_xact.is_io, host_xact.addr);
      x_tp = x_tc && !host_xact.is_io &&
        (mh(0, host_xact.addr) ? m[9][24] : m[9][25]);
      x_th = card_xact.valid && !hit(card_xact.is_io, card_xact.addr);
      x_lo = cfg_cyc_valid && cfg_cyc_bus == m[0][7:0];
      x_t0 = cfg_cyc_valid && !x_lo && cfg_cyc_bus == m[0][15:8];
      x_t1 = cfg_cyc_valid && !x_lo && cfg_cyc_bus > m[0][15:8] &&
        cfg_cyc_bus <= m[0][23:16];
      x_end = ts == 2 && init_active && data_phase_done;
      case (ts)
        0: if (frame_start) begin
          tc = m[0][31:24];
          ts = tc == 0 ? 2 : 1;
        end
        1: if (!init_active) ts = 0;
          else if (cclk_tick) begin
            tc = tc - 1;
            if (tc == 0) ts = 2;
          end
        default: if (!init_active || data_phase_done) ts = 0;
      endcase
      // own index and mask: the tenure count and stimulus word stay intact
      if (cfg_req.wr && ix(cfg_req.addr) < 10) begin
        wi = ix(cfg_req.addr);
        wm = {{8{cfg_req.be[3]}}, {8{cfg_req.be[2]}}, {8{cfg_req.be[1]}},
          {8{cfg_req.be[0]}}};
        m[wi] = ((m[wi] & ~wm) | (cfg_req.wdata & wm)) & mk(wi);
      end
    end
  end

  task chk(string n, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask

  always @(negedge core_clk) begin
    if (chk_on) begin
      chk("cfg_rdata", cfg_rdata, x_rd);
      chk("cfg_rvalid", cfg_rvalid, x_rv);
      chk("to_card", to_card, x_tc);
      chk("to_card_pref", to_card_pref, x_tp);
      chk("to_host", to_host, x_th);
      chk("cfg_local", cfg_local, x_lo);
      chk("cfg_type0", cfg_type0, x_t0);
      chk("cfg_type1", cfg_type1, x_t1);
      chk("tenure_expired", tenure_expired, ts == 2);
      chk("end_xact", end_xact, x_end);
    end
  end
  task acc(logic w, logic rd, logic [7:0] a, logic [31:0] d, logic [3:0] b);
    @(negedge core_clk);
    cfg_req <= '{w, rd, a, b, d};
    @(negedge core_clk);
    cfg_req <= '0;
  endtask
  task dec(int n);
    logic [31:0] v;
    repeat (n) begin
      v = xs();
      @(negedge core_clk);
      host_xact <= '{v[8], v[9], pick(v)};
      card_xact <= '{v[10], v[11], pick(xs())};
      cfg_cyc_valid <= v[12];
      cfg_cyc_bus <= {3'h0, v[17:13]};
    end
    @(negedge core_clk);
    host_xact <= '0;
    card_xact <= '0;
    cfg_cyc_valid <= 1'b0;
  endtask
  // one initiator tenure with a given timer value and data phase count
  task runx(logic [7:0] ten, logic [7:0] ph);
    int k;
    acc(1'b1, 1'b1, 8'h1B, {ten, 24'h0}, 4'h8);
    @(negedge core_clk);
    go <= 1'b1;
    phases <= ph;
    @(negedge core_clk);
    go <= 1'b0;
    @(negedge core_clk);
    k = 0;
    while (init_active && k < 3000) begin
      @(negedge core_clk);
      k++;
    end
    if (k == 3000) errors++;
  endtask
  task wrap_up();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      wrap_up();
    end
  end

  initial begin
    logic [31:0] cv [9] = '{32'h20141005, 32'h10000000, 32'h10003000,
      32'h10002000, 32'h20005000, 32'h100, 32'h1FF, 32'h0, 32'h0};
    {errors, n_checks, cyc} = '0;
    st = 32'd93497;
    {resetn, go, chk_on, cfg_cyc_valid} = '0;
    {phases, cfg_cyc_bus} = '0;
    {cfg_req, host_xact, card_xact} = '0;
    clk_en = 1'b1;
    repeat (4) @(negedge core_clk);
    resetn = 1'b1;
    chk_on = 1'b1;
    // reset image of every dword, then decode with all windows closed
    for (int a = 8'h14; a <= 8'h40; a += 4)
      acc(1'b0, 1'b1, a[7:0], 32'h00000000, 4'h0);
    dec(20);
    // random register traffic, clock enable dropped now and then
    repeat (80) begin
      r = xs();
      clk_en <= r[31:29] != 3'h0;
      acc(r[0], r[1], 8'h10 + {2'h0, r[7:2]}, xs(), r[11:8]);
    end
    clk_en <= 1'b1;
    for (int i = 0; i < 9; i++) acc(1'b1, 1'b0, 8'h18 + 8'(4 * i), cv[i], 4'hF);
    for (int p = 0; p < 4; p++) begin
      acc(1'b1, 1'b0, 8'h3E, {6'h0, p[1:0], 24'h0}, 4'h8);
      dec(150);
    end
    runx(8'h00, 8'd3);
    runx(8'h02, 8'd6);
    runx(8'h20, 8'd40);
    runx(8'h20, 8'd4);
    wrap_up();
  end
endmodule
`default_nettype wire
